// ---- design/current_sense_ocp_config.v ----
`timescale 1ns/1ps
`include "cs_ocp_consts.vh"

module current_sense_ocp_config (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    input  wire        clk_en,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata,
    // pins
    input  wire [2:0]  overcurrent_pin,
    input  wire        pwm_edge,
    // analog controls
    output reg  [6:0]  amp_gain_vv,
    output reg         gain_source_pin_select,
    output reg  [2:0]  amp_enable,
    output reg         dc_calibration_request,
    output reg         power_stage_hiz,
    // protection
    output reg         pwm_truncate,
    output reg         overcurrent_fault,
    output reg         irq
);

    // ***********************************************************
    // registers
    // ***********************************************************
    reg [15:0] current_sense_amp_config;
    reg [15:0] current_sense_amp_config_ext;
    reg [1:0]  irq_status_reg;
    reg [1:0]  irq_enable_reg;
    reg [4:0]  event_count_reg;
    reg [2:0]  oc_meta_reg;
    reg [2:0]  oc_sync_reg;
    reg        pwm_meta_reg;
    reg        pwm_sync_reg;
    reg        pwm_prev_reg;
    reg        filt_prev_reg;

    wire       blanking;
    wire       filtered;
    wire       pwm_rise  = pwm_sync_reg & ~pwm_prev_reg;
    wire       trunc_dis = current_sense_amp_config_ext[`TRUNC_DIS_BIT];
    wire [1:0] flt_cfg   = current_sense_amp_config[`FLT_CFG_MSB:`FLT_CFG_LSB];
    wire [2:0] amp_en    = current_sense_amp_config[`AMP_EN_MSB:`AMP_EN_LSB];
    wire       oc_raw    = |(oc_sync_reg & amp_en) & ~blanking;
    wire       oc_event  = filtered & ~filt_prev_reg;
    wire       fault_hit;
    wire       wr_clear  = reg_write && reg_addr == `ADDR_IRQ_CLEAR;

    // ***********************************************************
    // gain decode
    // ***********************************************************
    function [6:0] gain_of;
        input [2:0] code;
        begin
            case (code)
                3'h6:    gain_of = 7'd32;
                3'h7:    gain_of = 7'd64;
                default: gain_of = {2'd0, code + 3'd1, 2'd0};
            endcase
        end
    endfunction

    // ***********************************************************
    // input synchronisers
    // ***********************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            oc_meta_reg  <= 3'd0;
            oc_sync_reg  <= 3'd0;
            pwm_meta_reg <= 1'b0;
            pwm_sync_reg <= 1'b0;
            pwm_prev_reg <= 1'b0;
        end else if (clk_en) begin
            oc_meta_reg  <= overcurrent_pin;
            oc_sync_reg  <= oc_meta_reg;
            pwm_meta_reg <= pwm_edge;
            pwm_sync_reg <= pwm_meta_reg;
            pwm_prev_reg <= pwm_sync_reg;
        end
    end

    // ***********************************************************
    // blanking and deglitch
    // ***********************************************************
    blank_timer u_blank (
        .core_clk   (core_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .start      (pwm_rise),
        .blank_code (current_sense_amp_config[`BLANK_MSB:`BLANK_LSB]),
        .blanking   (blanking)
    );

    deglitch_filter u_deglitch (
        .core_clk      (core_clk),
        .rst           (rst),
        .clk_en        (clk_en),
        .deglitch_code (current_sense_amp_config[`DEGLITCH_MSB:`DEGLITCH_LSB]),
        .bypass        (~trunc_dis),
        .raw_in        (oc_raw),
        .filtered      (filtered)
    );

    // ***********************************************************
    // event counting and fault
    // ***********************************************************
    assign fault_hit = oc_event && (
        (flt_cfg == `FLT_EVERY) ||
        (flt_cfg == `FLT_COUNT8 && event_count_reg + 5'd1 >= `EVENTS_FEW) ||
        (flt_cfg == `FLT_COUNT16 && event_count_reg + 5'd1 >= `EVENTS_MANY));

    always @(posedge core_clk) begin
        if (rst) begin
            filt_prev_reg     <= 1'b0;
            event_count_reg   <= 5'd0;
            overcurrent_fault <= 1'b0;
        end else if (clk_en) begin
            filt_prev_reg <= filtered;
            if (oc_event && event_count_reg != 5'h1f)
                event_count_reg <= event_count_reg + 5'd1;
            if (fault_hit)
                overcurrent_fault <= 1'b1;
            else if (wr_clear && reg_wdata[`IRQ_FAULT_BIT]) begin
                overcurrent_fault <= 1'b0;
                event_count_reg   <= 5'd0;
            end
        end
    end

    // ***********************************************************
    // register writes and interrupt
    // ***********************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            current_sense_amp_config     <= `RESET_CFG;
            current_sense_amp_config_ext <= `RESET_CFG_EXT;
            irq_status_reg               <= 2'd0;
            irq_enable_reg               <= 2'd0;
        end else if (clk_en) begin
            if (reg_write && reg_addr == `ADDR_CFG)
                current_sense_amp_config <= reg_wdata;
            if (reg_write && reg_addr == `ADDR_CFG_EXT)
                current_sense_amp_config_ext <= reg_wdata;
            if (reg_write && reg_addr == `ADDR_IRQ_ENABLE)
                irq_enable_reg <= reg_wdata[1:0];
            irq_status_reg <= (irq_status_reg & ~(wr_clear ? reg_wdata[1:0] : 2'b00))
                            | {fault_hit, oc_event};
        end
    end

    // ***********************************************************
    // read port and outputs
    // ***********************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata              <= 16'h0000;
            amp_gain_vv            <= 7'd0;
            gain_source_pin_select <= 1'b0;
            amp_enable             <= 3'd0;
            dc_calibration_request <= 1'b0;
            power_stage_hiz        <= 1'b0;
            pwm_truncate           <= 1'b0;
            irq                    <= 1'b0;
        end else if (clk_en) begin
            if (!reg_read)
                reg_rdata <= 16'h0000;
            else if (reg_addr == `ADDR_CFG)
                reg_rdata <= current_sense_amp_config;
            else if (reg_addr == `ADDR_CFG_EXT)
                reg_rdata <= current_sense_amp_config_ext;
            else if (reg_addr == `ADDR_IRQ_STATUS)
                reg_rdata <= {14'd0, irq_status_reg};
            else if (reg_addr == `ADDR_IRQ_ENABLE)
                reg_rdata <= {14'd0, irq_enable_reg};
            else if (reg_addr == `ADDR_EVENT_COUNT)
                reg_rdata <= {11'd0, event_count_reg};
            else
                reg_rdata <= 16'h0000;
            amp_gain_vv <= gain_of(current_sense_amp_config[`GAIN_MSB:`GAIN_LSB]);
            gain_source_pin_select <= current_sense_amp_config[`GAIN_SRC_BIT];
            amp_enable <= amp_en;
            dc_calibration_request <= current_sense_amp_config[`DCCAL_BIT];
            power_stage_hiz <= current_sense_amp_config[`DCCAL_BIT];
            pwm_truncate <= filtered & ~trunc_dis;
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

endmodule // current_sense_ocp_config

// ---- include/cs_ocp_consts.vh ----
`ifndef CS_OCP_CONSTS_VH
`define CS_OCP_CONSTS_VH

// ***********************************************************
// register map
// ***********************************************************
`define ADDR_CFG            8'h1d
`define ADDR_CFG_EXT        8'h1e
`define ADDR_IRQ_STATUS     8'h20
`define ADDR_IRQ_ENABLE     8'h21
`define ADDR_IRQ_CLEAR      8'h22
`define ADDR_EVENT_COUNT    8'h23
`define RESET_CFG           16'h0028
`define RESET_CFG_EXT       16'h0833

// ***********************************************************
// field positions
// ***********************************************************
`define GAIN_LSB            0
`define GAIN_MSB            2
`define GAIN_SRC_BIT        3
`define AMP_EN_LSB          4
`define AMP_EN_MSB          6
`define BLANK_LSB           7
`define BLANK_MSB           10
`define DCCAL_BIT           11
`define DEGLITCH_LSB        12
`define DEGLITCH_MSB        13
`define FLT_CFG_LSB         14
`define FLT_CFG_MSB         15
`define TRUNC_DIS_BIT       11

// ***********************************************************
// fault trigger codes and counts
// ***********************************************************
`define FLT_COUNT8          2'b00
`define FLT_COUNT16         2'b01
`define FLT_EVERY           2'b10
`define FLT_NONE            2'b11
`define EVENTS_FEW          8
`define EVENTS_MANY         16

// ***********************************************************
// timing, in ns, and clock period
// ***********************************************************
`define CLK_PERIOD_NS       10
`define DEGLITCH_2US_NS     2000
`define DEGLITCH_4US_NS     4000
`define DEGLITCH_8US_NS     8000

// ***********************************************************
// interrupt bits
// ***********************************************************
`define IRQ_EVENT_BIT       0
`define IRQ_FAULT_BIT       1

`endif

// ---- design/blank_timer.v ----
`timescale 1ns/1ps
`include "cs_ocp_consts.vh"

module blank_timer (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    input  wire        clk_en,
    // control
    input  wire        start,
    input  wire [3:0]  blank_code,
    // status
    output reg         blanking
);

    reg [9:0] cnt_reg;

    // ***********************************************************
    // blanking code to cycles
    // ***********************************************************
    function [9:0] blank_cycles;
        input [3:0] code;
        begin
            case (code)
                4'h0: blank_cycles = 10'd0;
                4'h1: blank_cycles = 10'd5;
                4'h2: blank_cycles = 10'd10;
                4'hb: blank_cycles = 10'd100;
                4'hc: blank_cycles = 10'd200;
                4'hd: blank_cycles = 10'd400;
                4'he: blank_cycles = 10'd600;
                4'hf: blank_cycles = 10'd800;
                default: blank_cycles = {6'd0, code} * 10'd10 - 10'd10;
            endcase
        end
    endfunction

    always @(posedge core_clk) begin
        if (rst) begin
            cnt_reg  <= 10'd0;
            blanking <= 1'b0;
        end else if (clk_en) begin
            if (start && blank_cycles(blank_code) != 10'd0) begin
                cnt_reg  <= blank_cycles(blank_code) - 10'd1;
                blanking <= 1'b1;
            end else if (cnt_reg != 10'd0) begin
                cnt_reg <= cnt_reg - 10'd1;
            end else begin
                blanking <= 1'b0;
            end
        end
    end

endmodule // blank_timer

// ---- design/deglitch_filter.v ----
`timescale 1ns/1ps
`include "cs_ocp_consts.vh"

module deglitch_filter (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    input  wire        clk_en,
    // control
    input  wire [1:0]  deglitch_code,
    input  wire        bypass,
    input  wire        raw_in,
    // output
    output reg         filtered
);

    // integer quotients, cut to counter width on purpose
    localparam integer CYC_2US_I = `DEGLITCH_2US_NS / `CLK_PERIOD_NS;
    localparam integer CYC_4US_I = `DEGLITCH_4US_NS / `CLK_PERIOD_NS;
    localparam integer CYC_8US_I = `DEGLITCH_8US_NS / `CLK_PERIOD_NS;
    localparam [9:0]   CYC_2US   = CYC_2US_I[9:0];
    localparam [9:0]   CYC_4US   = CYC_4US_I[9:0];
    localparam [9:0]   CYC_8US   = CYC_8US_I[9:0];

    reg [9:0] cnt_reg;
    reg [9:0] need;

    always @* begin
        case (deglitch_code)
            2'b01:   need = CYC_2US;
            2'b10:   need = CYC_4US;
            2'b11:   need = CYC_8US;
            default: need = 10'd0;
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            cnt_reg  <= 10'd0;
            filtered <= 1'b0;
        end else if (clk_en) begin
            if (!raw_in) begin
                cnt_reg  <= 10'd0;
                filtered <= 1'b0;
            end else if (bypass || need == 10'd0) begin
                filtered <= 1'b1;
            end else if (cnt_reg + 10'd1 >= need) begin
                filtered <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 10'd1;
            end
        end
    end

endmodule // deglitch_filter

// ---- verification/ocp_cfg_asserts.sv ----
`timescale 1ns/1ps
`include "cs_ocp_consts.vh"
module ocp_cfg_checker (
    // clock and reset
    input logic        core_clk,
    input logic        rst,
    input logic        clk_en,
    // register port
    input logic [7:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [15:0] reg_rdata,
    // pins
    input logic [2:0]  overcurrent_pin,
    input logic        pwm_edge,
    // outputs
    input logic [6:0]  amp_gain_vv,
    input logic        gain_source_pin_select,
    input logic [2:0]  amp_enable,
    input logic        dc_calibration_request,
    input logic        power_stage_hiz,
    input logic        pwm_truncate,
    input logic        overcurrent_fault,
    input logic        irq
);
    logic [9:0]  quiet_cnt;
    logic [15:0] wd_q;
    function automatic logic [6:0] gain_of(input logic [2:0] c);
        case (c)
            3'h6: gain_of = 7'h20;
            3'h7: gain_of = 7'h40;
            default: gain_of = {2'b00, c, 2'b00} + 7'h04;
        endcase
    endfunction
    // cycles since any comparator was last high
    always @(posedge core_clk) begin
        if (rst || overcurrent_pin != 3'h0) quiet_cnt <= 10'h000;
        else if (quiet_cnt != 10'h3ff) quiet_cnt <= quiet_cnt + 10'h001;
    end
    always @(posedge core_clk) begin
        if (clk_en && reg_write && reg_addr == `ADDR_CFG) wd_q <= reg_wdata;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_cfg_take;
        clk_en && reg_write && reg_addr == `ADDR_CFG
        ##1 clk_en && !(reg_write && reg_addr == `ADDR_CFG);
    endsequence
    sequence s_irq_off;
        clk_en && reg_write && reg_addr == `ADDR_IRQ_ENABLE && reg_wdata[1:0] == 2'h0
        ##1 clk_en && !(reg_write && reg_addr == `ADDR_IRQ_ENABLE);
    endsequence
    property p_rdata_idle;
        clk_en && !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    property p_unmapped;
        clk_en && reg_read && !(reg_addr inside {`ADDR_CFG, `ADDR_CFG_EXT, `ADDR_IRQ_STATUS,
            `ADDR_IRQ_ENABLE, `ADDR_IRQ_CLEAR, `ADDR_EVENT_COUNT}) |=> reg_rdata == 16'h0000;
    endproperty
    property p_cfg_fields;
        s_cfg_take |=> amp_enable == wd_q[6:4] && gain_source_pin_select == wd_q[3]
            && dc_calibration_request == wd_q[11];
    endproperty
    property p_gain;
        s_cfg_take |=> amp_gain_vv == gain_of(wd_q[2:0]);
    endproperty
    property p_hiz;
        dc_calibration_request |-> power_stage_hiz;
    endproperty
    property p_irq_mask;
        s_irq_off |=> !irq;
    endproperty
    property p_fault_sticky;
        clk_en && overcurrent_fault && !(reg_write && reg_addr == `ADDR_IRQ_CLEAR
            && reg_wdata[`IRQ_FAULT_BIT]) |=> overcurrent_fault;
    endproperty
    property p_trunc_quiet;
        quiet_cnt >= 10'h3e8 |-> !pwm_truncate;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_cfg_fields: assert property (p_cfg_fields) else $error("cfg fields wrong");
    a_gain: assert property (p_gain) else $error("gain decode wrong");
    a_hiz: assert property (p_hiz) else $error("stages driven in calibration");
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped");
    a_trunc_quiet: assert property (p_trunc_quiet) else $error("truncate w/o cause");
endmodule // ocp_cfg_checker
bind current_sense_ocp_config ocp_cfg_checker ocp_cfg_checker_inst (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .overcurrent_pin(overcurrent_pin), .pwm_edge(pwm_edge),
    .amp_gain_vv(amp_gain_vv), .gain_source_pin_select(gain_source_pin_select),
    .amp_enable(amp_enable), .dc_calibration_request(dc_calibration_request),
    .power_stage_hiz(power_stage_hiz), .pwm_truncate(pwm_truncate),
    .overcurrent_fault(overcurrent_fault), .irq(irq));

// ---- verification/current_sense_ocp_config_tb_top.sv ----
`timescale 1ns/1ps
`include "cs_ocp_consts.vh"
module current_sense_ocp_config_tb_top;
    logic        core_clk, rst, clk_en, reg_write, reg_read, pwm_edge, src, cal, hiz;
    logic        trunc, fault, irq;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0]  pin, amp_en;
    logic [6:0]  gain;
    int          err_total, n_checks, cycles;
    logic [6:0]  gains [8] = '{7'h04, 7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h40};
    current_sense_ocp_config current_sense_ocp_config_inst (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .overcurrent_pin(pin), .pwm_edge(pwm_edge),
        .amp_gain_vv(gain), .gain_source_pin_select(src), .amp_enable(amp_en),
        .dc_calibration_request(cal), .power_stage_hiz(hiz), .pwm_truncate(trunc),
        .overcurrent_fault(fault), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        chk(what, reg_rdata, exp);
    endtask
    task automatic pulse(input int hi, input int lo, input logic t);
        @(posedge core_clk);
        pin <= 3'h1;
        idle(hi);
        @(negedge core_clk);
        chk("pwm_truncate", {15'h0, trunc}, {15'h0, t});
        @(posedge core_clk);
        pin <= 3'h0;
        idle(lo);
        @(negedge core_clk);
    endtask
    task automatic fault_is(input logic f);
        chk("overcurrent_fault", {15'h0, fault}, {15'h0, f});
    endtask
    function automatic logic [15:0] cfgv(input logic [1:0] f, g, input logic [3:0] b);
        cfgv = {f, g, 1'b0, b, 3'b111, 1'b0, 3'b000};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        int n;
        rst = 1'b1;
        clk_en = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        pin = 3'h0;
        pwm_edge = 1'b0;
        idle(10);
        rst <= 1'b0;
        rd(`ADDR_CFG, 16'h0028, "cfg reset");
        rd(`ADDR_CFG_EXT, 16'h0833, "ext reset");
        chk("gain reset", {9'h0, gain}, 16'h0004);
        wr(`ADDR_CFG, 16'hfa52);
        rd(`ADDR_CFG, 16'hfa52, "cfg rw");
        chk("gain src", {15'h0, src}, 16'h0000);
        chk("hiz", {15'h0, hiz}, 16'h0001);
        chk("cal", {15'h0, cal}, 16'h0001);
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000, "unmapped");
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(`ADDR_CFG, 16'h1234);
        clk_en <= 1'b1;
        rd(`ADDR_CFG, 16'hfa52, "frozen write");
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wr(`ADDR_CFG, {9'h000, 3'(1 << (i % 3)), 1'b0, i[2:0]});
            idle(2);
            @(negedge core_clk);
            chk("gain", {9'h0, gain}, {9'h0, gains[i]});
            chk("amp enable", {13'h0, amp_en}, {13'h0, 3'(1 << (i % 3))});
            chk("hiz off", {15'h0, hiz}, 16'h0000);
        end
        $display("test fields done");
        wr(`ADDR_IRQ_ENABLE, 16'h0003);
        wr(`ADDR_CFG_EXT, 16'h0033);
        for (int c = 0; c < 4; c++) begin
            n = (c == 1) ? 16 : (c == 2) ? 1 : 8;
            wr(`ADDR_IRQ_CLEAR, 16'h0003);
            wr(`ADDR_CFG, cfgv(c[1:0], 2'h0, 4'h0));
            repeat (n - 1) pulse(6, 8, 1'b1);
            fault_is(1'b0);
            pulse(6, 8, 1'b1);
            fault_is(c != 3);
            chk("irq", {15'h0, irq}, 16'h0001);
            rd(`ADDR_EVENT_COUNT, 16'(n), "event count");
        end
        wr(`ADDR_IRQ_ENABLE, 16'h0000);
        idle(2);
        @(negedge core_clk);
        chk("masked irq", {15'h0, irq}, 16'h0000);
        rd(`ADDR_IRQ_STATUS, 16'h0001, "status");
        wr(`ADDR_IRQ_CLEAR, 16'h0003);
        rd(`ADDR_IRQ_STATUS, 16'h0000, "status cleared");
        $display("test fault counts done");
        wr(`ADDR_CFG, cfgv(2'h2, 2'h3, 4'h0));
        pulse(6, 8, 1'b1);
        fault_is(1'b1);
        wr(`ADDR_CFG_EXT, 16'h0833);
        for (int g = 1; g < 4; g++) begin
            wr(`ADDR_IRQ_CLEAR, 16'h0003);
            wr(`ADDR_CFG, cfgv(2'h2, g[1:0], 4'h0));
            pulse((100 << g) - 50, 10, 1'b0);
            fault_is(1'b0);
            pulse((100 << g) + 50, 10, 1'b0);
            fault_is(1'b1);
        end
        $display("test deglitch done");
        wr(`ADDR_IRQ_CLEAR, 16'h0003);
        wr(`ADDR_CFG, cfgv(2'h2, 2'h0, 4'hb));
        pwm_edge <= 1'b1;
        idle(2);
        pulse(30, 10, 1'b0);
        fault_is(1'b0);
        @(posedge core_clk);
        pwm_edge <= 1'b0;
        idle(100);
        pulse(30, 10, 1'b0);
        fault_is(1'b1);
        idle(1010);
        $display("test blanking done");
        test_done();
    end
endmodule // current_sense_ocp_config_tb_top
